// ---- hdl/ssi_enc_pkg.sv ----
// Shared constants for the serial absolute encoder port and its master
package ssi_enc_pkg;
  // Word layout: multiturn field above the singleturn field
  localparam int SINGLE_TURN_BITS = 14;
  localparam int MULTI_TURN_BITS = 24;
  localparam int WORD_BITS = SINGLE_TURN_BITS + MULTI_TURN_BITS;
  localparam int CNT_W = $clog2(WORD_BITS + 2);
  // Build-time options
  localparam logic GRAY_CODE = 1'b0;
  localparam logic DIR_INVERT = 1'b0;
  localparam logic [WORD_BITS-1:0] PRESET_VALUE = 38'h00_0000_0000;
  // Clock and times in their own units
  localparam int MCLK_MHZ = 100;
  localparam int MONO_NS = 15000;
  localparam int PRESET_DLY_US = 1000;
  localparam int REFRESH_US = 2000;
  localparam int POWERON_US = 150000;
  localparam int PROC_US = 200000;
  localparam int SCK_MAX_KHZ = 2000;
  localparam int SCK_MIN_KHZ = 50;
  // Derived cycle counts (the monoflop time in ns rounds down)
  localparam int MONO_CYC = MONO_NS * MCLK_MHZ / 1000;
  localparam int MONO_W = $clog2(MONO_CYC + 1);
  localparam int PRESET_DLY_CYC = PRESET_DLY_US * MCLK_MHZ;
  localparam int REFRESH_CYC = REFRESH_US * MCLK_MHZ;
  localparam int POWERON_CYC = POWERON_US * MCLK_MHZ;
  localparam int PROC_CYC = PROC_US * MCLK_MHZ;
  // Half period of the generated shift clock, rounded up so the rate stays in range
  localparam int HALF_CYC = (MCLK_MHZ * 1000 + 2 * SCK_MAX_KHZ - 1) / (2 * SCK_MAX_KHZ);
  localparam int HALF_MAX_CYC = MCLK_MHZ * 1000 / (2 * SCK_MIN_KHZ);
  localparam int HALF_W = $clog2(HALF_CYC + 1);
  localparam int EDGE_LAST = 2 * (WORD_BITS + 1);
  localparam int EDGE_W = $clog2(EDGE_LAST + 1);
  // Master register map
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] POS_LO_OFS = 12'h008;
  localparam logic [11:0] POS_HI_OFS = 12'h00C;
  localparam int CTRL_START_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  typedef enum logic [0:0] {
    HOST_IDLE = 1'b0,
    HOST_RUN = 1'b1
  } host_state_t;
endpackage

// ---- hdl/ssi_encoder_device.sv ----
// Encoder end: position count, preset, direction, monoflop and serial shifter
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module ssi_encoder_device
  import ssi_enc_pkg::*;
#(
  parameter int PRESET_DLY = PRESET_DLY_CYC,
  parameter int REFRESH = REFRESH_CYC,
  parameter int POWERON = POWERON_CYC,
  parameter int PROCESS = PROC_CYC
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  ssi_link_if.device link,
  input wire logic [WORD_BITS-1:0] shaft_pos_i,
  input wire logic preset_i,
  input wire logic direction_i,
  output logic pos_valid_o,
  output logic preset_busy_o
);

  // Pin synchronisers: shift clock, preset, direction
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [2:0] pin_s3_q;
  logic [2:0] pin_clean_q;
  logic [2:0] pin_clean_d;

  logic sck_prev_q;
  logic sck_clean;
  logic preset_lvl;
  logic dir_lvl;
  logic sck_fall;
  logic sck_active;

  logic [MONO_W-1:0] mono_cnt_q;
  logic rearm_q;
  logic mono_expired;

  logic [31:0] pwr_cnt_q;
  logic pwr_ok_q;
  logic [31:0] ref_cnt_q;
  logic ref_tick;
  logic [31:0] pre_cnt_q;
  logic pre_apply;
  logic snap_req_q;
  logic [31:0] proc_cnt_q;

  logic [WORD_BITS-1:0] offset_q;
  logic [WORD_BITS-1:0] raw_dir;
  logic [WORD_BITS-1:0] pos_cur;
  logic [WORD_BITS-1:0] snap_q;
  logic [WORD_BITS-1:0] coded;
  logic [WORD_BITS-1:0] tx_word_q;

  // Link domain state
  logic [CNT_W-1:0] bit_cnt_q;
  logic [WORD_BITS-1:0] shift_q;
  logic [WORD_BITS-1:0] held_q;
  logic dout_q;

  // A bit changes once the second and third stages agree
  assign pin_clean_d = (pin_s2_q & pin_s3_q) | (pin_clean_q & (pin_s2_q | pin_s3_q));
  assign sck_clean = pin_clean_q[2];
  assign preset_lvl = pin_clean_q[1];
  assign dir_lvl = pin_clean_q[0];
  assign sck_fall = sck_prev_q & ~sck_clean;
  assign sck_active = sck_prev_q ^ sck_clean;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pin_s1_q <= 3'h4;
      pin_s2_q <= 3'h4;
      pin_s3_q <= 3'h4;
      pin_clean_q <= 3'h4;
      sck_prev_q <= 1'b1;
    end else begin
      pin_s1_q <= {link.ssi_clk, preset_i, direction_i};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_clean_q <= pin_clean_d;
      sck_prev_q <= sck_clean;
    end
  end

  // Monoflop: restarts on every clock edge, expires after a quiet high clock
  assign mono_expired = (mono_cnt_q == MONO_W'(MONO_CYC - 1)) && sck_clean && !sck_active;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mono_cnt_q <= '0;
      rearm_q <= 1'b1;
    end else begin
      if (sck_active || !sck_clean) begin
        mono_cnt_q <= '0;
      end else if (!mono_expired) begin
        mono_cnt_q <= mono_cnt_q + 1'b1;
      end
      if (sck_fall) begin
        rearm_q <= 1'b0;
      end else if (mono_expired) begin
        rearm_q <= 1'b1;
      end
    end
  end

  // Power-on hold-off and refresh timer
  assign ref_tick = (ref_cnt_q == 32'(REFRESH - 1));

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pwr_cnt_q <= '0;
      pwr_ok_q <= 1'b0;
      ref_cnt_q <= '0;
    end else begin
      if (pwr_cnt_q == 32'(POWERON - 1)) begin
        pwr_ok_q <= 1'b1;
      end else begin
        pwr_cnt_q <= pwr_cnt_q + 32'h1;
      end
      ref_cnt_q <= ref_tick ? 32'h0 : ref_cnt_q + 32'h1;
    end
  end

  // Direction and preset applied to the raw shaft count
  assign raw_dir = (dir_lvl ^ DIR_INVERT) ? WORD_BITS'(~shaft_pos_i + 1'b1) : shaft_pos_i;
  assign pos_cur = WORD_BITS'(raw_dir - offset_q + PRESET_VALUE);
  assign pre_apply = preset_lvl && (pre_cnt_q == 32'(PRESET_DLY - 1));

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pre_cnt_q <= '0;
      offset_q <= '0;
      snap_req_q <= 1'b0;
      proc_cnt_q <= '0;
    end else begin
      if (!preset_lvl) begin
        pre_cnt_q <= '0;
      end else if (pre_cnt_q != 32'(PRESET_DLY)) begin
        pre_cnt_q <= pre_cnt_q + 32'h1;
      end
      if (pre_apply) begin
        offset_q <= raw_dir;
      end
      snap_req_q <= pre_apply;
      if (pre_apply) begin
        proc_cnt_q <= 32'(PROCESS);
      end else if (proc_cnt_q != 32'h0) begin
        proc_cnt_q <= proc_cnt_q - 32'h1;
      end
    end
  end

  // Singleturn in the low bits, so MSB first sends multiturn first
  assign coded = GRAY_CODE ? (snap_q ^ (snap_q >> 1)) : snap_q;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      snap_q <= '0;
      tx_word_q <= '0;
    end else begin
      if (ref_tick || snap_req_q) begin
        snap_q <= pos_cur;
      end
      if (rearm_q) begin
        tx_word_q <= coded;
      end
    end
  end

  // Link side: tx_word_q is frozen while rearm_q is low, so it is stable here.
  // rearm_q clears the shifter while the link clock stands still.
  always_ff @(posedge link.ssi_clk or posedge rearm_q) begin
    if (rearm_q) begin
      bit_cnt_q <= '0;
      shift_q <= '0;
      held_q <= '0;
      dout_q <= 1'b1;
    end else begin
      case (bit_cnt_q)
        CNT_W'(0): begin
          held_q <= tx_word_q;
          shift_q <= tx_word_q << 1;
          dout_q <= tx_word_q[WORD_BITS-1];
          bit_cnt_q <= CNT_W'(1);
        end
        CNT_W'(WORD_BITS): begin
          dout_q <= 1'b0;
          bit_cnt_q <= CNT_W'(WORD_BITS + 1);
        end
        CNT_W'(WORD_BITS + 1): begin
          shift_q <= held_q << 1;
          dout_q <= held_q[WORD_BITS-1];
          bit_cnt_q <= CNT_W'(1);
        end
        default: begin
          dout_q <= shift_q[WORD_BITS-1];
          shift_q <= shift_q << 1;
          bit_cnt_q <= bit_cnt_q + 1'b1;
        end
      endcase
    end
  end

  // Line held low until the power-on time has passed
  assign link.ssi_data = dout_q & pwr_ok_q;
  assign pos_valid_o = pwr_ok_q;
  assign preset_busy_o = (proc_cnt_q != 32'h0);

endmodule // ssi_encoder_device

// ---- hdl/ssi_link_if.sv ----
// Two-wire synchronous serial link between position master and encoder
`timescale 1ns/1ps
interface ssi_link_if;
  logic ssi_clk;
  logic ssi_data;
  modport device (
    input ssi_clk,
    output ssi_data
  );
  modport host (
    output ssi_clk,
    input ssi_data
  );
endinterface

// ---- hdl/ssi_master_host.sv ----
// Master end: APB registers, shift clock divider and word capture
`timescale 1ns/1ps
module ssi_master_host
  import ssi_enc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  ssi_link_if.host link,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);

  host_state_t state_q;
  logic [HALF_W-1:0] half_cnt_q;
  logic [EDGE_W-1:0] edge_q;
  logic sck_q;
  logic [WORD_BITS-1:0] rx_q;
  logic [WORD_BITS-1:0] pos_q;
  logic done_q;
  logic din_s1_q;
  logic din_s2_q;
  logic din_s3_q;
  logic din_q;
  logic [31:0] prdata_q;

  logic setup;
  logic wr;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_lo;
  logic hit_hi;
  logic mapped;
  logic start;
  logic half_tick;
  logic frame_end;
  logic [31:0] rd_mux;

  assign setup = psel_i && !penable_i;
  assign wr = psel_i && penable_i && pwrite_i;
  assign hit_ctrl = (paddr_i == CTRL_OFS);
  assign hit_stat = (paddr_i == STATUS_OFS);
  assign hit_lo = (paddr_i == POS_LO_OFS);
  assign hit_hi = (paddr_i == POS_HI_OFS);
  assign mapped = hit_ctrl | hit_stat | hit_lo | hit_hi;
  assign start = wr && hit_ctrl && pwdata_i[CTRL_START_BIT] && (state_q == HOST_IDLE);
  assign half_tick = (half_cnt_q == HALF_W'(HALF_CYC - 1));
  assign frame_end = half_tick && (edge_q == EDGE_W'(EDGE_LAST));
  assign rd_mux = hit_stat ? {30'h0, done_q, state_q == HOST_RUN} :
                  hit_lo ? pos_q[31:0] :
                  hit_hi ? {{(64 - WORD_BITS){1'b0}}, pos_q[WORD_BITS-1:32]} : 32'h0;

  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;
  assign prdata_o = prdata_q;
  assign link.ssi_clk = sck_q;

  // Data pin passes three stages and changes once the last two agree
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      din_s1_q <= 1'b1;
      din_s2_q <= 1'b1;
      din_s3_q <= 1'b1;
      din_q <= 1'b1;
      prdata_q <= 32'h0;
    end else begin
      din_s1_q <= link.ssi_data;
      din_s2_q <= din_s1_q;
      din_s3_q <= din_s2_q;
      if (din_s2_q == din_s3_q) begin
        din_q <= din_s3_q;
      end
      if (setup) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // Burst: first fall latches, each later fall samples one bit MSB first
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_q <= HOST_IDLE;
      half_cnt_q <= '0;
      edge_q <= '0;
      sck_q <= 1'b1;
      rx_q <= '0;
      pos_q <= '0;
      done_q <= 1'b0;
    end else begin
      case (state_q)
        HOST_IDLE: begin
          if (start) begin
            state_q <= HOST_RUN;
            sck_q <= 1'b0;
            edge_q <= EDGE_W'(1);
            half_cnt_q <= '0;
          end
        end
        HOST_RUN: begin
          half_cnt_q <= half_tick ? '0 : half_cnt_q + 1'b1;
          if (frame_end) begin
            state_q <= HOST_IDLE;
            pos_q <= rx_q;
          end else if (half_tick) begin
            sck_q <= ~sck_q;
            edge_q <= edge_q + 1'b1;
            if (sck_q) begin
              rx_q <= {rx_q[WORD_BITS-2:0], din_q};
            end
          end
        end
        default: begin
          state_q <= HOST_IDLE;
        end
      endcase
      if (frame_end) begin
        done_q <= 1'b1;
      end else if (wr && hit_stat && pwdata_i[STAT_DONE_BIT]) begin
        done_q <= 1'b0;
      end
    end
  end

endmodule // ssi_master_host

// ---- verif/ssi_link_props.sv ----
// Checker for the serial link between master and encoder
`timescale 1ns/1ps
module ssi_link_props
  import ssi_enc_pkg::*;
#(
  parameter int PROCESS = PROC_CYC
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ssi_clk,
  input wire logic ssi_data,
  input wire logic pos_valid_o,
  input wire logic preset_busy_o
);
  logic [7:0] lo_q;
  logic [7:0] hi_q;
  logic [11:0] idle_q;
  logic [6:0] fall_q;
  logic [31:0] busy_q;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // Cycles since the last shift clock edge, saturating except the low-phase count
  always_ff @(posedge mclk_i) begin
    lo_q <= (reset_i || ssi_clk) ? 8'h00 : lo_q + 8'h01;
    hi_q <= (reset_i || !ssi_clk) ? 8'h00 : ((&hi_q) ? hi_q : hi_q + 8'h01);
    idle_q <= (reset_i || $changed(ssi_clk)) ? 12'h000 : ((&idle_q) ? idle_q : idle_q + 12'h001);
    busy_q <= preset_busy_o ? busy_q + 32'h1 : 32'h0;
    if (reset_i || idle_q == 12'h01E) begin
      fall_q <= 7'h00;
    end else if ($fell(ssi_clk)) begin
      fall_q <= fall_q + 7'h01;
    end
  end
  AST_CLK_LOW_HALF: assert property ($rose(ssi_clk) |-> int'(lo_q) == HALF_CYC)
    else $error("shift clock low phase wrong length");
  AST_CLK_HIGH_MIN: assert property ($fell(ssi_clk) |-> int'(hi_q) >= HALF_CYC)
    else $error("shift clock high phase too short");
  AST_NO_DATA_EARLY: assert property (!pos_valid_o |-> !ssi_data)
    else $error("data line high before power-on time");
  AST_VALID_HOLDS: assert property (pos_valid_o |=> pos_valid_o)
    else $error("valid flag dropped");
  AST_DATA_ON_RISE: assert property (
    $changed(ssi_data) && $past(pos_valid_o, 2) && idle_q < 12'h028 |-> $rose(ssi_clk))
    else $error("data changed away from a rising shift edge");
  AST_MONO_RISE: assert property (
    $rose(ssi_data) && $past(pos_valid_o, 2) && idle_q > 12'h028
    |-> int'(idle_q) >= MONO_CYC && int'(idle_q) <= MONO_CYC + 12)
    else $error("ready level returned at wrong time");
  AST_READY_BOUND: assert property (
    idle_q > 12'h5F0 && pos_valid_o && $past(pos_valid_o, 2) |-> ssi_data)
    else $error("data line low long after burst");
  AST_FRAME_EDGES: assert property (
    idle_q == 12'h01E && fall_q != 7'h00 |-> int'(fall_q) == WORD_BITS + 1)
    else $error("burst edge count wrong");
  AST_BUSY_LEN: assert property ($fell(preset_busy_o) |-> int'(busy_q) == PROCESS)
    else $error("preset busy time wrong");
  cover property ($rose(preset_busy_o));
  cover property ($rose(ssi_data) && idle_q > 12'h028);
  cover property (idle_q == 12'h01E && int'(fall_q) == WORD_BITS + 1);
endmodule // ssi_link_props

// ---- verif/tb.sv ----
// Bench joining master and encoder over the serial link
`timescale 1ns/1ps
module tb;
  import ssi_enc_pkg::*;
  typedef struct packed {logic dir; logic [37:0] shaft; logic [37:0] pos;} row_t;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [37:0] shaft_pos = 38'h0;
  logic preset = 1'b0;
  logic direction = 1'b0;
  logic pos_valid;
  logic preset_busy;
  int errors = 0;
  int total_checks = 0;
  row_t rows [4] = '{'{1'b0, 38'h00_0000_0000, 38'h00_0000_0000},
    '{1'b0, 38'h3F_FFFF_FFFF, 38'h3F_FFFF_FFFF}, '{1'b0, 38'h2A_AAAA_5555, 38'h2A_AAAA_5555},
    '{1'b1, 38'h00_0000_0001, 38'h3F_FFFF_FFFF}};
  always #5 mclk_i = ~mclk_i;
  ssi_link_if ssi_link_if_i ();
  ssi_encoder_device #(.PRESET_DLY(50), .REFRESH(200), .POWERON(100), .PROCESS(100))
    ssi_encoder_device_i (.mclk_i(mclk_i), .reset_i(reset_i), .link(ssi_link_if_i.device),
    .shaft_pos_i(shaft_pos), .preset_i(preset), .direction_i(direction),
    .pos_valid_o(pos_valid), .preset_busy_o(preset_busy));
  ssi_master_host ssi_master_host_i (.mclk_i(mclk_i), .reset_i(reset_i),
    .link(ssi_link_if_i.host), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr));
  ssi_link_props #(.PROCESS(100)) ssi_link_props_i (.mclk_i(mclk_i), .reset_i(reset_i),
    .ssi_clk(ssi_link_if_i.ssi_clk), .ssi_data(ssi_link_if_i.ssi_data),
    .pos_valid_o(pos_valid), .preset_busy_o(preset_busy));
  task automatic chk(input string name, input logic [37:0] exp, input logic [37:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    @(posedge mclk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge mclk_i);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Start a burst, wait for done, fetch the word and clear done
  task automatic frame(output logic [37:0] p);
    logic [31:0] q;
    logic e;
    apb(1'b1, CTRL_OFS, 32'h1, q, e);
    for (int n = 0; n < 1000; n++) begin
      apb(1'b0, STATUS_OFS, 32'h0, q, e);
      if (q[STAT_DONE_BIT] === 1'b1) break;
    end
    apb(1'b0, POS_LO_OFS, 32'h0, q, e);
    p[31:0] = q;
    apb(1'b0, POS_HI_OFS, 32'h0, q, e);
    p[37:32] = q[5:0];
    apb(1'b1, STATUS_OFS, 32'h1 << STAT_DONE_BIT, q, e);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    logic [37:0] p;
    logic [31:0] q;
    logic e;
    repeat (12) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    chk("data_early", 38'h0, 38'(ssi_link_if_i.ssi_data));
    repeat (120) @(posedge mclk_i);
    chk("valid", 38'h1, 38'(pos_valid));
    chk("ready_line", 38'h1, 38'(ssi_link_if_i.ssi_data));
    $display("test power_on done");
    foreach (rows[i]) begin
      direction <= rows[i].dir;
      shaft_pos <= rows[i].shaft;
      repeat (1700) @(posedge mclk_i);
      frame(p);
      chk("row_pos", rows[i].pos, p);
    end
    $display("test rows done");
    direction <= 1'b0;
    shaft_pos <= 38'h00_0000_1234;
    repeat (1700) @(posedge mclk_i);
    frame(p);
    shaft_pos <= 38'h00_0000_5678;
    frame(p);
    chk("repeat_pos", 38'h00_0000_1234, p);
    repeat (1700) @(posedge mclk_i);
    frame(p);
    chk("fresh_pos", 38'h00_0000_5678, p);
    $display("test monoflop done");
    preset <= 1'b1;
    repeat (60) @(posedge mclk_i);
    preset <= 1'b0;
    #1;
    chk("preset_busy", 38'h1, 38'(preset_busy));
    repeat (1700) @(posedge mclk_i);
    frame(p);
    chk("preset_pos", PRESET_VALUE, p);
    shaft_pos <= 38'h00_0000_567D;
    preset <= 1'b1;
    repeat (20) @(posedge mclk_i);
    preset <= 1'b0;
    repeat (1700) @(posedge mclk_i);
    frame(p);
    chk("short_preset", PRESET_VALUE + 38'h5, p);
    $display("test preset done");
    apb(1'b0, 12'h010, 32'h0, q, e);
    chk("unmapped_err", 38'h1, 38'(e));
    chk("unmapped_data", 38'h0, 38'(q));
    chk("pready", 38'h1, 38'(pready));
    $display("test unmapped done");
    reset_i <= 1'b1;
    repeat (12) @(posedge mclk_i);
    #1;
    chk("reset_valid", 38'h0, 38'(pos_valid));
    chk("reset_data", 38'h0, 38'(ssi_link_if_i.ssi_data));
    chk("reset_busy", 38'h0, 38'(preset_busy));
    @(posedge mclk_i);
    reset_i <= 1'b0;
    repeat (120) @(posedge mclk_i);
    #1;
    chk("revalid", 38'h1, 38'(pos_valid));
    chk("reready_line", 38'h1, 38'(ssi_link_if_i.ssi_data));
    $display("test reset done");
    final_report();
  end
  initial begin
    #600000;
    errors++;
    final_report();
  end
endmodule // tb
